// ===== test/sci_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sci_properties
    import sci_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [SCI_AW-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [SCI_DW-1:0] wb_dat_i,
    input wire logic [SCI_DW-1:0] wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              irq_o,
    input wire logic              brownout_reset_o
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the masks; it updates at the same edge as the design.
    logic [6:0] mask_q;
    logic [6:0] mask_d;
    always_comb begin
        mask_d = mask_q;
        if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
            && wb_adr_i == SCI_OFF_MASK) begin
            mask_d = wb_dat_i[6:0];
        end
        if (rst_i) begin
            mask_d = 7'h00;
        end
    end
    always_ff @(posedge clk_i) begin
        mask_q <= mask_d;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack late");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");
    property p_upper;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:7] == 25'h000_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_mask_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == SCI_OFF_MASK
            |-> wb_dat_o[6:0] == mask_q;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask read");
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h60 |-> wb_dat_o == SCI_ZERO_WORD;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole read");
    property p_irq_mask;
        $rose(irq_o) |=> mask_q != 7'h00;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("irq unmasked");
    property p_irq_off;
        mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq no mask");
    property p_route;
        mask_q == 7'h02 && $past(mask_q) == 7'h02 && brownout_reset_o
            |-> !irq_o;
    endproperty
    a_route: assert property (p_route)
        else $error("irq while routed");
    c_irq: cover property ($rose(irq_o));
    c_route: cover property ($rose(brownout_reset_o));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind sci_top sci_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .brownout_reset_o(brownout_reset_o)
);

`default_nettype wire

// ===== test/tb_sysctl_interrupt_status_mask.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sysctl_interrupt_status_mask
    import sci_pkg::*;
();
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cyc   = 1'b0;
    logic              we    = 1'b0;
    logic [3:0]        sel   = 4'h0;
    logic [SCI_AW-1:0] adr   = 8'h00;
    logic [SCI_DW-1:0] wdat  = 32'h0000_0000;
    logic [6:0]        det   = 7'h00;
    logic [SCI_DW-1:0] rdat;
    logic [SCI_DW-1:0] r;
    logic              ack;
    logic              irq;
    logic              bor_rst;
    int                fail_count = 0;
    int                n_checks   = 0;

    sci_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .pll_fault_i(det[0]), .brownout_i(det[1]),
        .regulator_unregulated_i(det[2]), .main_osc_fault_i(det[3]),
        .internal_osc_fault_i(det[4]), .current_limit_i(det[5]),
        .pll_lock_i(det[6]), .irq_o(irq), .brownout_reset_o(bor_rst)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // Waits on ack as long as it takes; only the watchdog ends a dead wait.
    task automatic bus(input logic [7:0]  a,
                       input logic        w,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
    endtask
    task automatic pulse(input logic [6:0] v);
        @(posedge clk_i);
        det <= v;
        @(posedge clk_i);
        det <= 7'h00;
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        chk("irq", 32'(irq), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(SCI_OFF_RAW, 1'b0, 0);
        chk("raw", r, 32'h0000_0000);
        bus(SCI_OFF_MASK, 1'b0, 0);
        chk("mask", r, 32'h0000_0000);
        bus(SCI_OFF_MASK, 1'b1, 32'hFFFF_FFFF);
        bus(SCI_OFF_MASK, 1'b0, 0);
        chk("mask", r, 32'h0000_007F);
        bus(8'h60, 1'b0, 0);
        chk("hole", r, 32'h0000_0000);
        bus(SCI_OFF_MASK, 1'b1, 32'h0000_0000);
    endtask
    task automatic t_brownout;
        pulse(7'h02);
        bus(SCI_OFF_RAW, 1'b0, 0);
        chk("raw", r, 32'h0000_0002);
        irq_is(1'b0);
        bus(SCI_OFF_MASK, 1'b1, 32'h0000_0002);
        irq_is(1'b1);
        bus(SCI_OFF_MCLR, 1'b0, 0);
        chk("enabled", r, 32'h0000_0002);
        bus(SCI_OFF_BORCTL, 1'b1, 32'h0000_0002);
        irq_is(1'b0);
        bus(SCI_OFF_BORCTL, 1'b0, 0);
        chk("route_bit", r, 32'h0000_0002);
        chk("route", 32'(bor_rst), 32'h0000_0001);
        bus(SCI_OFF_BORCTL, 1'b1, 32'h0000_0000);
        irq_is(1'b1);
        bus(SCI_OFF_MCLR, 1'b1, 32'h0000_0002);
        irq_is(1'b0);
    endtask
    task automatic t_sources;
        logic [31:0] m;
        for (int i = 0; i < 7; i++) begin
            m = 32'h0000_0001 << i;
            pulse(m[6:0]);
            bus(SCI_OFF_MASK, 1'b1, ~m & 32'h0000_007F);
            irq_is(1'b0);
            bus(SCI_OFF_MASK, 1'b1, m);
            irq_is(1'b1);
            bus(SCI_OFF_MCLR, 1'b1, m);
            irq_is(1'b0);
        end
        bus(SCI_OFF_MASK, 1'b1, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_brownout;
        t_sources;
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        tally_and_finish;
    end
endmodule

`default_nettype wire

// ===== verilog/sci_event_latch.sv
`timescale 1ns/1ps
`default_nettype none

module sci_event_latch
    import sci_pkg::*;
#(
    parameter int                N   = SCI_NSRC,
    parameter logic [N-1:0]      RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] flags_o
);

    logic [N-1:0] flags_d;
    logic [N-1:0] flags_q;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        flags_d = set_i | (flags_q & ~clr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule

`default_nettype wire

// ===== verilog/sci_pkg.sv
`default_nettype none

package sci_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int SCI_NSRC = 7;
    localparam int SCI_AW   = 8;
    localparam int SCI_DW   = 32;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [SCI_AW-1:0] SCI_OFF_BORCTL = 8'h30;
    localparam logic [SCI_AW-1:0] SCI_OFF_RAW    = 8'h50;
    localparam logic [SCI_AW-1:0] SCI_OFF_MASK   = 8'h54;
    localparam logic [SCI_AW-1:0] SCI_OFF_MCLR   = 8'h58;

    ////////////////////////////////////////////////////////////////////////
    localparam int SCI_BIT_PLLF  = 0;
    localparam int SCI_BIT_BOR   = 1;
    localparam int SCI_BIT_LDO   = 2;
    localparam int SCI_BIT_MOF   = 3;
    localparam int SCI_BIT_IOF   = 4;
    localparam int SCI_BIT_CL    = 5;
    localparam int SCI_BIT_PLLL  = 6;
    localparam int SCI_BIT_ROUTE = 1;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [SCI_NSRC-1:0] SCI_MASK_RST  = 7'h00;
    localparam logic [SCI_NSRC-1:0] SCI_RAW_RST   = 7'h00;
    localparam logic                SCI_ROUTE_RST = 1'b0;
    localparam logic [SCI_DW-1:0]   SCI_ZERO_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    typedef logic [SCI_NSRC-1:0] sci_src_t;

    typedef struct packed {
        logic [SCI_AW-1:0] adr;
        logic              we;
        logic [3:0]        sel;
        logic [SCI_DW-1:0] dat;
    } sci_wb_req_t;

    typedef enum logic [1:0] {
        SCI_BUS_IDLE = 2'b01,
        SCI_BUS_ACK  = 2'b10
    } sci_bus_state_t;

endpackage

`default_nettype wire

// ===== verilog/sci_top.sv
// Summary of operation
// (RQ1) Raw status bit 1 is the read-only brown-out flag, zero after reset.
// (RQ2) Any brown-out detection sets the brown-out flag so it reads as one.
// (RQ3) Brown-out interrupts only with its mask set and reset routing clear.
// (RQ4) The mask register answers at offset 0x054.
// (RQ5) The mask register has seven R/W bits 6..0, reset zero, upper bits zero.
// (RQ6) Each source interrupts only when its mask bit and raw flag are set.
// (RQ7) The interrupt request is the OR of every raw flag ANDed with its mask; brown-out also needs reset routing clear.
`timescale 1ns/1ps
`default_nettype none

module sci_top
    import sci_pkg::*;
#(
    parameter int NSRC = SCI_NSRC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [SCI_AW-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [SCI_DW-1:0] wb_dat_i,
    output logic      [SCI_DW-1:0] wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              pll_fault_i,
    input  wire logic              brownout_i,
    input  wire logic              regulator_unregulated_i,
    input  wire logic              main_osc_fault_i,
    input  wire logic              internal_osc_fault_i,
    input  wire logic              current_limit_i,
    input  wire logic              pll_lock_i,
    output logic                   irq_o,
    output logic                   brownout_reset_o
);

    ////////////////////////////////////////////////////////////////////////
    // Word-aligned decode; the two low address bits are not part of it.
    function automatic logic hit(input logic [SCI_AW-1:0] adr,
                                 input logic [SCI_AW-1:0] off);
        hit = (adr[SCI_AW-1:2] == off[SCI_AW-1:2]);
    endfunction

    // Narrow registers sit in the low bits and the rest reads zero.
    function automatic logic [SCI_DW-1:0] widen(input sci_src_t v);
        widen = SCI_ZERO_WORD;
        widen[SCI_NSRC-1:0] = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    sci_wb_req_t    req;
    sci_bus_state_t bus_q;
    sci_bus_state_t bus_d;
    logic           ack_d;
    logic           ack_q;
    logic [SCI_DW-1:0] rdat_d;
    logic [SCI_DW-1:0] rdat_q;
    logic           wr_en;
    logic           wr_low;

    sci_src_t       mask_d;
    sci_src_t       mask_q;
    logic           route_d;
    logic           route_q;
    sci_src_t       raw_set;
    sci_src_t       raw_clr;
    sci_src_t       raw_flags;
    sci_src_t       enabled;
    logic           irq_d;
    logic           irq_q;
    logic           bor_rst_d;
    logic           bor_rst_q;

    assign req.adr = wb_adr_i;
    assign req.we  = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i;

    ////////////////////////////////////////////////////////////////////////
    // One-cycle answer: ack rises the edge after the request is seen and
    // drops the edge after, and a request still held then is taken again at the next edge.
    always_comb begin
        bus_d  = bus_q;
        ack_d  = 1'b0;
        rdat_d = rdat_q;
        unique case (bus_q)
            SCI_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_d  = SCI_BUS_ACK;
                    ack_d  = 1'b1;
                    rdat_d = SCI_ZERO_WORD;
                    if (hit(req.adr, SCI_OFF_RAW)) begin
                        rdat_d = widen(raw_flags); // [RQ1]
                    end else if (hit(req.adr, SCI_OFF_MASK)) begin
                        rdat_d = widen(mask_q); // [RQ4] [RQ5]
                    end else if (hit(req.adr, SCI_OFF_MCLR)) begin
                        rdat_d = widen(enabled);
                    end else if (hit(req.adr, SCI_OFF_BORCTL)) begin
                        rdat_d[SCI_BIT_ROUTE] = route_q;
                    end
                end
            end
            SCI_BUS_ACK: begin
                bus_d = SCI_BUS_IDLE;
            end
            default: begin
                bus_d = SCI_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q  <= SCI_BUS_IDLE;
            ack_q  <= 1'b0;
            rdat_q <= SCI_ZERO_WORD;
        end else begin
            bus_q  <= bus_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////
    // Writes take effect at the edge at which the master sees ack high;
    // all fields live in byte lane 0, so a write without it changes nothing.
    assign wr_en  = (bus_q == SCI_BUS_ACK) && wb_cyc_i && wb_stb_i
                    && req.we;
    assign wr_low = wr_en && req.sel[0];

    always_comb begin
        mask_d  = mask_q;
        route_d = route_q;
        raw_clr = '0;
        if (wr_low && hit(req.adr, SCI_OFF_MASK)) begin
            mask_d = req.dat[SCI_NSRC-1:0]; // [RQ4] [RQ5]
        end
        if (wr_low && hit(req.adr, SCI_OFF_BORCTL)) begin
            route_d = req.dat[SCI_BIT_ROUTE];
        end
        if (wr_low && hit(req.adr, SCI_OFF_MCLR)) begin
            raw_clr = req.dat[SCI_NSRC-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q  <= SCI_MASK_RST; // [RQ5]
            route_q <= SCI_ROUTE_RST;
        end else begin
            mask_q  <= mask_d;
            route_q <= route_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector levels are sampled every cycle; a flag stays set after the
    // condition goes away until software clears it.
    always_comb begin
        raw_set = '0;
        raw_set[SCI_BIT_PLLF] = pll_fault_i;
        raw_set[SCI_BIT_BOR]  = brownout_i; // [RQ2]
        raw_set[SCI_BIT_LDO]  = regulator_unregulated_i;
        raw_set[SCI_BIT_MOF]  = main_osc_fault_i;
        raw_set[SCI_BIT_IOF]  = internal_osc_fault_i;
        raw_set[SCI_BIT_CL]   = current_limit_i;
        raw_set[SCI_BIT_PLLL] = pll_lock_i;
    end

    sci_event_latch #(
        .N   (SCI_NSRC),
        .RST (SCI_RAW_RST)
    ) u_raw (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (raw_set),
        .clr_i   (raw_clr),
        .flags_o (raw_flags)
    ); // [RQ1] [RQ2]

    ////////////////////////////////////////////////////////////////////////
    // Brown-out routed to reset is withheld from the interrupt path so the
    // processor is not interrupted by an event that is resetting it.
    always_comb begin
        enabled = raw_flags & mask_q; // [RQ6] [RQ7]
        enabled[SCI_BIT_BOR] = raw_flags[SCI_BIT_BOR] & mask_q[SCI_BIT_BOR]
                               & ~route_q; // [RQ3]
        irq_d     = |enabled; // [RQ7]
        bor_rst_d = raw_flags[SCI_BIT_BOR] & route_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q     <= 1'b0;
            bor_rst_q <= 1'b0;
        end else begin
            irq_q     <= irq_d;
            bor_rst_q <= bor_rst_d;
        end
    end

    assign irq_o            = irq_q;
    assign brownout_reset_o = bor_rst_q;

endmodule

`default_nettype wire
